// >>> sps_defines.svh
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define SPS_IDX_CON1_A   12'h0F95
`define SPS_IDX_CON1_B   12'h0E91
`define SPS_DLT_BUF      12'h0004
`define SPS_DLT_ADD      12'h0003
`define SPS_DLT_STAT     12'h0001
`define SPS_DLT_CON2     12'h0001
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SPS_B_SMP        7
`define SPS_B_CKE        6
`define SPS_B_DA         5
`define SPS_B_STOP       4
`define SPS_B_START      3
`define SPS_B_RW         2
`define SPS_B_UA         1
`define SPS_B_BF         0
`define SPS_B_WRITE_COLLISION_FLAG       7
`define SPS_B_OVF        6
`define SPS_B_EN         5
`define SPS_B_CKP        4
`define SPS_B_ACKNOWLEDGE_SEQUENCE_ENABLE      4
`define SPS_B_RECEIVE_ENABLE_BIT       3
`define SPS_B_PEN        2
`define SPS_B_REPEATED_START_ENABLE       1
`define SPS_B_SEN        0
// ----------------------------------------------------------------------------
// mode codes, reset values, counts
// ----------------------------------------------------------------------------
`define SPS_M_SPIM_D4    4'h0
`define SPS_M_SPIM_D16   4'h1
`define SPS_M_SPIM_D64   4'h2
`define SPS_M_SPIM_TMR   4'h3
`define SPS_M_SPIS_SS    4'h4
`define SPS_M_SPIS       4'h5
`define SPS_M_I2CS7      4'h6
`define SPS_M_I2CS10     4'h7
`define SPS_M_I2CM       4'h8
`define SPS_M_SPIM_ADD   4'hA
`define SPS_M_I2CFW      4'hB
`define SPS_M_I2CS7I     4'hE
`define SPS_M_I2CS10I    4'hF
`define SPS_RST_BYTE     8'h00
`define SPS_HALF_D4      16'h0002
`define SPS_HALF_D16     16'h0008
`define SPS_HALF_D64     16'h0020
`define SPS_BITS_BYTE    4'h8
`define SPS_BITS_I2C     4'h9
`define SPS_TENBIT_HDR   5'h1E
`endif

// >>> sps_pkg.sv
package sps_pkg;
  // master sequencer states
  typedef enum logic [3:0] {
    SPS_M_IDLE = 4'b0001,
    SPS_M_LEAD = 4'b0010,
    SPS_M_TRAIL = 4'b0100,
    SPS_M_COND = 4'b1000
  } sps_mst_e;

  // apb request from master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } sps_apb_req_t;

  // link pin inputs
  typedef struct packed {
    logic clk_pin;
    logic data_pin;
    logic select_n;
  } sps_pin_in_t;

  // link pin outputs with enables
  typedef struct packed {
    logic clk_pin;
    logic clk_pin_oe;
    logic data_pin;
    logic data_pin_oe;
  } sps_pin_out_t;
endpackage

// >>> sps_sync2.sv
`timescale 1ns/10ps
// two-flop synchroniser for pin levels
module sps_sync2 #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // ---------------------------------------------------------------------------
  // first stage feeds only the second stage
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// >>> sps_port.sv
`timescale 1ns/10ps
`include "sps_defines.svh"
module sps_port
  import sps_pkg::*;
#(
  parameter logic [11:0] CON1_INDEX = `SPS_IDX_CON1_A
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  sps_pkg::sps_apb_req_t apb_i,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic [31:0]        prdata_o,
  input  sps_pkg::sps_pin_in_t  pin_i,
  output sps_pkg::sps_pin_out_t pin_o,
  output logic               port_enable_o,
  output logic               slew_limit_o,
  output logic               smbus_levels_o,
  output logic               port_active_o
);
  import sps_pkg::*;

  typedef struct packed {
    logic [7:0]   stat;
    logic [7:0]   con1;
    logic [4:0]   seq;
    logic [7:0]   buf_q;
    logic [7:0]   addr;
    logic [7:0]   sh;
    logic [3:0]   bits;
    logic [15:0]  div;
    sps_mst_e     mst;
    logic         addr_phase;
    logic         matched;
    logic         slv_tx;
    logic         ack_drive;
    logic         clk_prev;
    logic         dat_prev;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    sps_pin_out_t pins;
    logic         active;
    logic         smp_bit;
    logic         slew;
    logic         smbus;
  } sps_state_t;

  sps_state_t  st;
  sps_state_t  next_st;
  sps_pin_in_t pin_s;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  sps_sync2 #(.W(3)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (pin_i),
    .q_o       (pin_s)
  );

  // mode decode
  logic [3:0]  mode;
  logic        spi_m, spi_s, i2c_s, i2c_m, is_i2c, ten_bit;
  logic        clk_rise, clk_fall, sda_rise, sda_fall;
  logic [11:0] idx;
  logic        acc, wr, rd;
  logic [15:0] half;

  assign mode    = st.con1[3:0];
  assign spi_m   = (mode <= `SPS_M_SPIM_TMR) || (mode == `SPS_M_SPIM_ADD);
  assign spi_s   = (mode == `SPS_M_SPIS_SS) || (mode == `SPS_M_SPIS);
  assign ten_bit = (mode == `SPS_M_I2CS10) || (mode == `SPS_M_I2CS10I);
  assign i2c_s   = ten_bit || (mode == `SPS_M_I2CS7) || (mode == `SPS_M_I2CS7I);
  assign i2c_m   = (mode == `SPS_M_I2CM) || (mode == `SPS_M_I2CFW);
  assign is_i2c  = i2c_s || i2c_m;
  assign clk_rise = pin_s.clk_pin & ~st.clk_prev;
  assign clk_fall = ~pin_s.clk_pin & st.clk_prev;
  assign sda_rise = pin_s.data_pin & ~st.dat_prev;
  assign sda_fall = ~pin_s.data_pin & st.dat_prev;

  // apb decode: request taken in the setup cycle
  assign idx = apb_i.paddr[13:2];
  assign acc = apb_i.psel & ~apb_i.penable & ~st.pready;
  assign wr  = acc & apb_i.pwrite;
  assign rd  = acc & ~apb_i.pwrite;

  // master half-bit length in system clocks
  always_comb begin
    case (mode)
      `SPS_M_SPIM_D4:  half = `SPS_HALF_D4;
      `SPS_M_SPIM_D16: half = `SPS_HALF_D16;
      `SPS_M_SPIM_D64: half = `SPS_HALF_D64;
      default:         half = {7'h00, st.addr, 1'b0} + `SPS_HALF_D4;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic       byte_in;
    logic       buf_wr;
    logic       buf_rd;
    logic       set_write_collision_flag;
    logic       set_ovf;
    logic       busy;
    logic       spi_sample;
    logic       spi_shift;
    logic [7:0] rx;
    byte_in  = 1'b0;
    buf_wr   = 1'b0;
    buf_rd   = 1'b0;
    set_write_collision_flag = 1'b0;
    set_ovf  = 1'b0;
    rx       = {st.sh[6:0], pin_s.data_pin};
    busy     = (st.mst != SPS_M_IDLE) || (spi_s && st.bits != 4'h0) || st.slv_tx;
    spi_sample = st.con1[`SPS_B_CKE] ? ((st.con1[`SPS_B_CKP]) ? clk_fall : clk_rise)
                                     : ((st.con1[`SPS_B_CKP]) ? clk_rise : clk_fall);
    spi_shift  = st.con1[`SPS_B_CKE] ? ((st.con1[`SPS_B_CKP]) ? clk_rise : clk_fall)
                                     : ((st.con1[`SPS_B_CKP]) ? clk_fall : clk_rise);
    next_st          = st;
    next_st.clk_prev = pin_s.clk_pin;
    next_st.dat_prev = pin_s.data_pin;
    next_st.pready   = acc;
    next_st.pslverr  = 1'b0;
    next_st.prdata   = 32'h0000_0000;

    // register reads and writes
    if (acc) begin
      if (idx == CON1_INDEX) begin
        next_st.prdata[7:0] = st.con1;
        if (wr) begin
          next_st.con1[5:0] = apb_i.pwdata[5:0];
          next_st.con1[`SPS_B_WRITE_COLLISION_FLAG] = st.con1[`SPS_B_WRITE_COLLISION_FLAG] & apb_i.pwdata[`SPS_B_WRITE_COLLISION_FLAG];
          next_st.con1[`SPS_B_OVF]  = st.con1[`SPS_B_OVF] & apb_i.pwdata[`SPS_B_OVF];
        end
      end else if (idx == CON1_INDEX - `SPS_DLT_STAT) begin
        next_st.prdata[7:0] = st.stat;
        if (wr) begin
          next_st.stat[`SPS_B_SMP] = apb_i.pwdata[`SPS_B_SMP];
          next_st.stat[`SPS_B_CKE] = apb_i.pwdata[`SPS_B_CKE];
        end
      end else if (idx == CON1_INDEX + `SPS_DLT_CON2) begin
        next_st.prdata[4:0] = st.seq;
        if (wr) begin
          next_st.seq = apb_i.pwdata[4:0];
        end
      end else if (idx == CON1_INDEX - `SPS_DLT_BUF) begin
        next_st.prdata[7:0] = st.buf_q;
        buf_wr = wr;
        buf_rd = rd;
      end else if (idx == CON1_INDEX - `SPS_DLT_ADD) begin
        next_st.prdata[7:0] = st.addr;
        if (wr) begin
          next_st.addr = apb_i.pwdata[7:0];
          next_st.stat[`SPS_B_UA] = 1'b0;
        end
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    // buffer read frees a received character
    if (buf_rd && !st.slv_tx && !(i2c_m && st.stat[`SPS_B_RW])) begin
      next_st.stat[`SPS_B_BF] = 1'b0;
    end

    // buffer write: load, start transmit or flag a collision
    if (buf_wr) begin
      next_st.buf_q = apb_i.pwdata[7:0];
      if (busy || (i2c_m && (st.seq != 5'h00))) begin
        set_write_collision_flag = 1'b1;
      end else if (spi_m || i2c_m) begin
        next_st.sh   = apb_i.pwdata[7:0];
        next_st.bits = i2c_m ? `SPS_BITS_I2C : `SPS_BITS_BYTE;
        next_st.div  = half;
        next_st.mst  = SPS_M_LEAD;
        next_st.stat[`SPS_B_BF] = 1'b1;
      end else if (spi_s || (i2c_s && st.stat[`SPS_B_RW] && st.matched)) begin
        next_st.sh     = apb_i.pwdata[7:0];
        next_st.slv_tx = i2c_s;
        next_st.stat[`SPS_B_BF] = 1'b1;
      end
    end

    // master sequencer: clock out one bit per lead/trail pair
    case (st.mst)
      SPS_M_IDLE: begin
        if (i2c_m && st.seq != 5'h00) begin
          next_st.div = half;
          next_st.mst = SPS_M_COND;
          if (st.seq[`SPS_B_RECEIVE_ENABLE_BIT]) begin
            next_st.sh   = 8'hFF;
            next_st.bits = `SPS_BITS_BYTE;
            next_st.mst  = SPS_M_LEAD;
          end
        end
      end
      SPS_M_LEAD: begin
        next_st.div = st.div - 16'h0001;
        if (st.div == 16'h0001) begin
          next_st.div = half;
          next_st.mst = SPS_M_TRAIL;
          if (!st.stat[`SPS_B_SMP]) begin
            next_st.smp_bit = pin_s.data_pin;
          end
        end
      end
      SPS_M_TRAIL: begin
        next_st.div = st.div - 16'h0001;
        if (st.div == 16'h0001) begin
          next_st.div  = half;
          next_st.bits = st.bits - 4'h1;
          // one shift per bit except the first of nine in i2c: with the sample bit clear, the mid-bit sample is held until the trailing half ends
          if (st.bits != `SPS_BITS_I2C) begin
            next_st.sh = {st.sh[6:0], st.stat[`SPS_B_SMP] ? pin_s.data_pin : st.smp_bit};
          end
          next_st.mst = (st.bits == 4'h1) ? SPS_M_IDLE : SPS_M_LEAD;
          if (st.bits == 4'h1) begin
            next_st.seq[`SPS_B_RECEIVE_ENABLE_BIT] = 1'b0;
            next_st.stat[`SPS_B_BF]  = spi_m | st.seq[`SPS_B_RECEIVE_ENABLE_BIT];
            if (spi_m || st.seq[`SPS_B_RECEIVE_ENABLE_BIT]) begin
              next_st.buf_q = {st.sh[6:0], st.stat[`SPS_B_SMP] ? pin_s.data_pin : st.smp_bit};
            end
          end
        end
      end
      SPS_M_COND: begin
        next_st.div = st.div - 16'h0001;
        if (st.div == 16'h0001) begin
          next_st.mst = SPS_M_IDLE;
          next_st.seq = 5'h00;
        end
      end
      default: next_st.mst = SPS_M_IDLE;
    endcase

    // spi slave: shift on pin edges, select low when enabled
    if (spi_s) begin
      if (mode == `SPS_M_SPIS_SS && pin_s.select_n) begin
        next_st.bits = 4'h0;
      end else if (spi_sample) begin
        next_st.sh   = rx;
        next_st.bits = (st.bits == 4'h7) ? 4'h0 : st.bits + 4'h1;
        byte_in      = (st.bits == 4'h7);
      end
    end

    // i2c slave: address and data bytes, the ack clock rise is also shifted in and counted
    if (i2c_s) begin
      if (clk_rise && st.bits != `SPS_BITS_BYTE) begin
        next_st.sh   = rx;
        next_st.bits = st.bits + 4'h1;
      end
      if (clk_fall && st.bits == `SPS_BITS_BYTE) begin
        if (st.addr_phase) begin
          next_st.addr_phase = 1'b0;
          next_st.stat[`SPS_B_DA] = 1'b0;
          if (ten_bit ? (st.sh[7:3] == `SPS_TENBIT_HDR) : (st.sh[7:1] == st.addr[7:1])) begin
            next_st.matched = 1'b1;
            next_st.stat[`SPS_B_RW] = st.sh[0];
            next_st.ack_drive = 1'b1;
            if (ten_bit) begin
              next_st.stat[`SPS_B_UA] = 1'b1;
            end
          end
        end else if (st.matched && !st.stat[`SPS_B_RW]) begin
          next_st.stat[`SPS_B_DA] = 1'b1;
          next_st.ack_drive = 1'b1;
          byte_in = 1'b1;
        end else if (st.slv_tx) begin
          next_st.stat[`SPS_B_DA] = 1'b1;
          next_st.slv_tx = 1'b0;
          next_st.stat[`SPS_B_BF] = 1'b0;
        end
        next_st.bits = `SPS_BITS_I2C;
      end else if (clk_fall && st.bits == `SPS_BITS_I2C) begin
        next_st.ack_drive = 1'b0;
        next_st.bits = 4'h0;
        if (st.slv_tx && pin_s.data_pin) begin
          next_st.stat[`SPS_B_RW] = 1'b0;
        end
      end else if (clk_fall && st.slv_tx) begin
        next_st.sh = {st.sh[6:0], st.sh[7]};
      end
    end

    // received byte into buffer, overflow if unread
    if (byte_in) begin
      if (st.stat[`SPS_B_BF]) begin
        set_ovf = 1'b1;
      end else begin
        next_st.buf_q = i2c_s ? st.sh : rx;
        next_st.stat[`SPS_B_BF] = 1'b1;
      end
    end

    // start and stop conditions seen on the bus
    if (is_i2c && pin_s.clk_pin && st.clk_prev) begin
      if (sda_fall) begin
        next_st.stat[`SPS_B_START] = 1'b1;
        next_st.stat[`SPS_B_STOP]  = 1'b0;
      end
      if (sda_rise) begin
        next_st.stat[`SPS_B_STOP]  = 1'b1;
        next_st.stat[`SPS_B_START] = 1'b0;
      end
      if (i2c_s && (sda_fall || sda_rise)) begin
        next_st.addr_phase = sda_fall;
        next_st.matched    = 1'b0;
        next_st.slv_tx     = 1'b0;
        next_st.ack_drive  = 1'b0;
        next_st.bits       = 4'h0;
        next_st.stat[`SPS_B_RW] = 1'b0;
      end
    end
    if (i2c_m) begin
      next_st.stat[`SPS_B_RW] = (next_st.mst != SPS_M_IDLE) && !next_st.seq[`SPS_B_RECEIVE_ENABLE_BIT];
    end

    // hardware sets win over software clears
    if (set_write_collision_flag && !spi_s && !(i2c_s && !st.stat[`SPS_B_RW])) begin
      next_st.con1[`SPS_B_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (set_ovf) begin
      next_st.con1[`SPS_B_OVF] = 1'b1;
    end
    if (set_write_collision_flag && spi_s) begin
      next_st.con1[`SPS_B_WRITE_COLLISION_FLAG] = 1'b1;
    end

    // disabled port: drop conditions and engine state
    if (!st.con1[`SPS_B_EN]) begin
      next_st.stat[`SPS_B_STOP:`SPS_B_START] = 2'b00;
      next_st.mst        = SPS_M_IDLE;
      next_st.bits       = 4'h0;
      next_st.matched    = 1'b0;
      next_st.slv_tx     = 1'b0;
      next_st.ack_drive  = 1'b0;
      next_st.addr_phase = 1'b0;
    end

    // pin drive
    next_st.pins = '0;
    if (st.con1[`SPS_B_EN]) begin
      if (spi_m) begin
        next_st.pins.clk_pin_oe  = 1'b1;
        next_st.pins.data_pin_oe = 1'b1;
        next_st.pins.data_pin    = next_st.sh[7];
        next_st.pins.clk_pin     = st.con1[`SPS_B_CKP] ^ (next_st.mst == SPS_M_TRAIL ? st.stat[`SPS_B_CKE]
                                   : (next_st.mst == SPS_M_LEAD) & ~st.stat[`SPS_B_CKE]);
      end else if (spi_s) begin
        next_st.pins.data_pin_oe = ~(mode == `SPS_M_SPIS_SS && pin_s.select_n);
        next_st.pins.data_pin    = (spi_shift || st.bits == 4'h0) ? next_st.sh[7] : st.pins.data_pin;
      end else if (i2c_s) begin
        next_st.pins.clk_pin_oe  = ~st.con1[`SPS_B_CKP];
        next_st.pins.data_pin_oe = next_st.ack_drive || (next_st.slv_tx && !next_st.sh[7]
                                   && next_st.bits < `SPS_BITS_BYTE);
      end else if (i2c_m) begin
        next_st.pins.clk_pin_oe  = (next_st.mst == SPS_M_LEAD) ||
                                   (next_st.mst == SPS_M_IDLE && st.mst == SPS_M_COND && st.seq[`SPS_B_SEN]);
        next_st.pins.data_pin_oe = (next_st.mst == SPS_M_COND) ? (st.seq[`SPS_B_PEN] == (next_st.div > half[15:1]))
                                   : (next_st.mst != SPS_M_IDLE && !next_st.seq[`SPS_B_RECEIVE_ENABLE_BIT] && !next_st.sh[7]
                                      && next_st.bits != 4'h1);
      end
    end
    next_st.active = next_st.stat[`SPS_B_RW] | (|next_st.seq);
    next_st.slew   = is_i2c & ~st.stat[`SPS_B_SMP];
    next_st.smbus  = is_i2c & st.stat[`SPS_B_CKE];
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st        <= '0;
      st.con1   <= `SPS_RST_BYTE;
      st.stat   <= `SPS_RST_BYTE;
      st.mst    <= SPS_M_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign pready_o       = st.pready;
  assign pslverr_o      = st.pslverr;
  assign prdata_o       = st.prdata;
  assign pin_o          = st.pins;
  assign port_enable_o  = st.con1[`SPS_B_EN];
  assign slew_limit_o   = st.slew;
  assign smbus_levels_o = st.smbus;
  assign port_active_o  = st.active;
endmodule

// >>> sps_port_assertions.sv
`timescale 1ns/10ps
module sps_port_chk
  import sps_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input sps_pkg::sps_apb_req_t  apb_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic [31:0]       prdata_o,
  input sps_pkg::sps_pin_out_t  pin_o,
  input wire logic              port_enable_o,
  input wire logic              slew_limit_o,
  input wire logic              smbus_levels_o
);
  logic [3:0] mode_sh;
  logic [1:0] st_sh;
  logic       wr_setup;
  logic       i2c_sh;
  // ----------------------------------------
  // shadow of the mode field and status bits
  // ----------------------------------------
  assign wr_setup = apb_i.psel && !apb_i.penable && apb_i.pwrite;
  assign i2c_sh = mode_sh inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
  // follow software writes to control one and status
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_sh <= 4'h0;
      st_sh <= 2'h0;
    end else if (wr_setup && apb_i.paddr == 16'h3e54) begin
      mode_sh <= apb_i.pwdata[3:0];
    end else if (wr_setup && apb_i.paddr == 16'h3e50) begin
      st_sh <= apb_i.pwdata[7:6];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_ready_after_setup: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    apb_i.psel && !apb_i.penable |=> pready_o) else $error("no ready after setup");
  a_ready_one_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pready_o |=> !pready_o) else $error("ready held too long");
  a_err_with_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pslverr_o |-> pready_o) else $error("error without ready");
  a_rdata_idle_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !pready_o |-> prdata_o == 32'h0000_0000) else $error("read data outside answer");
  a_slew_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$past(wr_setup) |-> slew_limit_o == (i2c_sh && !st_sh[1])) else $error("slew level wrong");
  a_smbus_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$past(wr_setup) |-> smbus_levels_o == (i2c_sh && st_sh[0])) else $error("smbus level wrong");
  a_enable_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_setup && apb_i.paddr == 16'h3e54 |-> ##2 port_enable_o == $past(apb_i.pwdata[5], 2))
    else $error("enable bit not taken");
  a_pins_released: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !port_enable_o [*3] |-> !pin_o.clk_pin_oe && !pin_o.data_pin_oe) else $error("pins driven while off");
endmodule

// >>> sps_spi_peer.sv
`timescale 1ns/10ps
// spi slave on the far side: shifts a fixed byte out on idle-to-active clock edges
module sps_spi_peer #(
  parameter logic [7:0] TX_BYTE  = 8'ha5,
  parameter logic       IDLE_LVL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk_i,
  input  wire logic sclk_oe_i,
  output logic      miso_o
);
  logic [7:0] shreg;
  logic       sclk_q;
  // outside frames the line holds no valid bit, so it toggles
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk_i;
    if (rst_i || !sclk_oe_i) begin
      shreg <= TX_BYTE;
      miso_o <= rst_i ? 1'b0 : !miso_o;
    end else if (sclk_i != sclk_q && sclk_i != IDLE_LVL) begin
      miso_o <= shreg[7];
      shreg <= {shreg[6:0], 1'b0};
    end
  end
endmodule

// >>> test_serial_port_status_control.sv
`timescale 1ns/10ps
module test_serial_port_status_control;
  import sps_pkg::*;
  localparam logic [15:0] A_BUF  = 16'h3e44;
  localparam logic [15:0] A_ADD  = 16'h3e48;
  localparam logic [15:0] A_STAT = 16'h3e50;
  localparam logic [15:0] A_CON1 = 16'h3e54;
  localparam logic [15:0] A_CON2 = 16'h3e58;
  logic         clk_i     = 1'b0;
  logic         sys_rst_i = 1'b1;
  sps_apb_req_t apb_i     = '0;
  sps_pin_in_t  pin_i;
  sps_pin_out_t pin_o;
  logic         pready_o, pslverr_o, port_enable_o, slew_limit_o, smbus_levels_o, port_active_o;
  logic [31:0]  prdata_o, q, r, seed;
  logic [31:0]  mdl [logic [15:0]];
  logic         e, miso, i2c_on, scl, sda;
  int           errors, compares, cycles;
  // ----------------------------------------
  // clock, pins, design and far side
  // ----------------------------------------
  always #25 clk_i = ~clk_i;
  // open-drain bus in i2c, peer data line in spi
  assign pin_i = '{clk_pin: i2c_on ? scl & !pin_o.clk_pin_oe : pin_o.clk_pin,
                   data_pin: i2c_on ? sda & !pin_o.data_pin_oe : miso, select_n: 1'b1};
  sps_port dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .apb_i(apb_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .port_enable_o(port_enable_o), .slew_limit_o(slew_limit_o),
    .smbus_levels_o(smbus_levels_o), .port_active_o(port_active_o));
  sps_spi_peer peer_u (.clk_i(clk_i), .rst_i(sys_rst_i), .sclk_i(pin_o.clk_pin),
    .sclk_oe_i(pin_o.clk_pin_oe), .miso_o(miso));
  // cuts a hung run short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    apb_i <= '0;
    @(posedge clk_i);
  endtask
  // write and keep the model in step: flags only clear from software
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == A_CON1) mdl[a] = (mdl[a] & d & 32'h0000_00c0) | (d & 32'h0000_003f);
    if (a == A_STAT) mdl[a] = d & 32'h0000_00c0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    check(q & m, x & m);
  endtask
  task automatic finish_test();
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i2c_on, scl, sda, seed} = {3'b011, 32'hfb2e_2d56};
    mdl[A_CON1] = 32'h0000_0000;
    mdl[A_STAT] = 32'h0000_0000;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_CON1, 32'h0000_0000, 32'h0000_00ff);
    rd(A_STAT, 32'h0000_0000, 32'h0000_00ff);
    apb(1'b0, 16'h0100, 32'h0000_0000);
    check(32'(e), 32'h0000_0001);
    // every mode code except 9, 12 and 13, with random edge bit and, except in spi slave modes, random sample bit, port off
    for (int m = 0; m < 16; m++) begin
      if (m inside {9, 12, 13}) continue;
      r = rnd();
      if (m inside {4, 5}) r[7] = 1'b0;
      wr(A_CON1, (r & 32'h0000_00c0) | 32'(m));
      wr(A_STAT, r);
      rd(A_CON1, mdl[A_CON1], 32'h0000_00ff);
      rd(A_STAT, mdl[A_STAT], 32'h0000_00c0);
      check(32'(slew_limit_o), 32'(m inside {6, 7, 8, 11, 14, 15} && !r[7]));
      check(32'(smbus_levels_o), 32'(m inside {6, 7, 8, 11, 14, 15} && r[6]));
    end
    // spi master, high idle clock, 400 ns link clock, second write while shifting
    wr(A_STAT, 32'h0000_0000);
    wr(A_ADD, 32'h0000_0001);
    wr(A_CON1, 32'h0000_003a);
    check(32'(pin_o.clk_pin), 32'h0000_0001);
    wr(A_BUF, 32'h0000_005a);
    wr(A_BUF, 32'h0000_00c3);
    mdl[A_CON1] |= 32'h0000_0080;
    rd(A_CON1, mdl[A_CON1], 32'h0000_00ff);
    repeat (60) @(posedge clk_i);
    rd(A_STAT, 32'h0000_0001, 32'h0000_0001);
    check(32'(pin_o.clk_pin), 32'h0000_0001);
    rd(A_BUF, 32'h0000_00a5, 32'h0000_00ff);
    rd(A_STAT, 32'h0000_0000, 32'h0000_0001);
    wr(A_CON1, 32'h0000_00f0);
    rd(A_CON1, mdl[A_CON1], 32'h0000_00ff);
    wr(A_CON1, 32'h0000_0030);
    rd(A_CON1, mdl[A_CON1], 32'h0000_00ff);
    wr(A_CON1, 32'h0000_0000);
    check(32'({pin_o.clk_pin_oe, pin_o.data_pin_oe}), 32'h0000_0000);
    // i2c slave: start then stop on a 400 ns bus clock, then disable
    i2c_on <= 1'b1;
    wr(A_CON1, 32'h0000_0036);
    sda <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(A_STAT, 32'h0000_0008, 32'h0000_0018);
    scl <= 1'b0;
    repeat (4) @(posedge clk_i);
    scl <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(A_STAT, 32'h0000_0010, 32'h0000_0018);
    wr(A_CON1, 32'h0000_0006);
    rd(A_STAT, 32'h0000_0000, 32'h0000_0018);
    // sequence enable bits alone make the port active
    wr(A_CON2, 32'h0000_0008);
    check(32'(port_active_o), 32'h0000_0001);
    wr(A_CON2, 32'h0000_0000);
    check(32'(port_active_o), 32'h0000_0000);
    finish_test();
  end
endmodule
bind sps_port sps_port_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .apb_i(apb_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .pin_o(pin_o),
  .port_enable_o(port_enable_o), .slew_limit_o(slew_limit_o), .smbus_levels_o(smbus_levels_o));
